// file: contact_bank.sv
// far side model: four external contacts (switches, floats, pressure switches)
// assumes the bench sets contact levels; chatter makes a contact bounce each cycle
module contact_bank (
	input  wire logic       ref_clk,
	input  wire logic [3:0] level,
	input  wire logic [3:0] chatter,
	output logic      [3:0] contact_out
);
	logic [3:0] bounce_q = 4'h0;

	// mechanical bounce while a contact is closing
	always_ff @(posedge ref_clk) begin
		bounce_q <= ~bounce_q & chatter;
	end

	assign contact_out = level ^ bounce_q;
endmodule

// file: pump_input_function_logic.sv
// auxiliary digital input qualification and function mapping
// assumes contacts arrive asynchronously on pins; registers on classic wishbone
// What this block does
// - each of four inputs maps to any function through its own code.
// - code zero on an input drives no function whatever its level.
// - code 3 selects aux setpoint normally-open, code 4 normally-closed.
// - asserted aux function of input i makes aux setpoint i the target.
// - aux setpoint taken only after input active continuously one second.
// - main setpoint restored only after input inactive continuously one second.
// - several aux functions asserted: regulate to the lowest of their setpoints.
// - aux indication up while any aux function asserted, cleared when none.
// - code 5 disables on present, code 6 on absent; else enabled.
// - codes 7,8 disable plus block reset; code 9 only resets blocks.
// - disable applied only after input active continuously one second.
// - re-enable only after disabling input inactive continuously one second.
// - disable indication up while any disable function asserted.
// - low-pressure function blocks only after the shutoff delay elapsed.
// - codes 10,12 present is low; 11,13 absent; 12,13 manual reset only.
// - low-pressure block releases only after input inactive two seconds.
// - low-pressure indication up while any low-pressure function asserted.
module pump_input_function_logic #(
	parameter int TICK_CYCLES = pump_input_pkg::TICK_CYCLES,
	parameter int N_INPUTS    = 4,
	parameter int SP_W        = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [N_INPUTS-1:0] auxiliary_digital_input,
	output logic      [SP_W-1:0]   regulation_setpoint,
	output logic                   aux_setpoint_indicator,
	output logic                   system_disabled_indicator,
	output logic                   resettable_block_reset,
	output logic                   low_pressure_block_indicator,
	output logic                   irq
);

	logic [3:0]      input_function_code [N_INPUTS];
	logic [SP_W-1:0] main_pressure_setpoint_q;
	logic [SP_W-1:0] aux_sp_q [N_INPUTS];
	logic [7:0]      low_pressure_shutoff_delay_q;
	logic [3:0]      irq_mask_q;
	logic [3:0]      irq_status_q;
	logic [3:0]      irq_mask_d;
	logic [31:0]     tick_cnt_q;
	logic            tick_q;
	logic [N_INPUTS-1:0] s1_q, s2_q, s3_q, lvl_q, qual_q, raw_w;
	logic [N_INPUTS-1:0] aux_fn, dis_fn, rst_fn, lp_fn, lp_man_fn;
	logic [17:0]     cnt_q [N_INPUTS];
	logic [17:0]     need_w [N_INPUTS];
	logic            man_latch_q;
	logic            lp_block_q;
	logic            manual_reset_w;
	logic [SP_W-1:0] target_w;
	logic [3:0]      events_w;
	logic            bus_req;
	logic            rd_status;
	logic [31:0]     rdata_w;
	logic [31:0]     wmask;
	logic [15:0]     codes_q;

	function automatic logic is_nc(input logic [3:0] c);
		return (c == pump_input_pkg::CODE_AUX_NC) || (c == pump_input_pkg::CODE_DIS_NC) ||
			(c == pump_input_pkg::CODE_DIS_RST_NC) || (c == pump_input_pkg::CODE_LP_AUTO_NC) ||
			(c == pump_input_pkg::CODE_LP_MAN_NC);
	endfunction

	function automatic logic is_lp(input logic [3:0] c);
		return (c >= pump_input_pkg::CODE_LP_AUTO_NO) && (c <= pump_input_pkg::CODE_LP_MAN_NC);
	endfunction

	// slow system tick shared by all input timers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_cnt_q <= 32'h00000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 32'h00000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			tick_q     <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_INPUTS; gi++) begin : g_in
			assign input_function_code[gi] = codes_q[gi*4 +: 4];

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					s1_q[gi]  <= 1'b0;
					s2_q[gi]  <= 1'b0;
					s3_q[gi]  <= 1'b0;
					lvl_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= auxiliary_digital_input[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						lvl_q[gi] <= s3_q[gi];
					end
				end
			end

			// active level per contact type
			assign raw_w[gi] = lvl_q[gi] ^ is_nc(input_function_code[gi]);

			// low pressure: shutoff delay to block, two seconds to release
			assign need_w[gi] = is_lp(input_function_code[gi]) ?
				(qual_q[gi] ? pump_input_pkg::UNBLOCK_TICKS :
				18'(low_pressure_shutoff_delay_q * pump_input_pkg::TICKS_PER_S)) :
				pump_input_pkg::QUAL_TICKS;

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					qual_q[gi] <= 1'b0;
					cnt_q[gi]  <= 18'h00000;
				end else if (raw_w[gi] == qual_q[gi]) begin
					cnt_q[gi] <= 18'h00000;
				end else if (cnt_q[gi] >= need_w[gi]) begin
					qual_q[gi] <= raw_w[gi];
					cnt_q[gi]  <= 18'h00000;
				end else if (tick_q) begin
					cnt_q[gi] <= cnt_q[gi] + 18'h00001;
				end
			end

			assign aux_fn[gi] = qual_q[gi] && ((input_function_code[gi] == pump_input_pkg::CODE_AUX_NO) ||
				(input_function_code[gi] == pump_input_pkg::CODE_AUX_NC));
			assign dis_fn[gi] = qual_q[gi] && (input_function_code[gi] >= pump_input_pkg::CODE_DIS_NO) &&
				(input_function_code[gi] <= pump_input_pkg::CODE_DIS_RST_NC);
			assign rst_fn[gi] = qual_q[gi] && (input_function_code[gi] >= pump_input_pkg::CODE_DIS_RST_NO) &&
				(input_function_code[gi] <= pump_input_pkg::CODE_RST_NO);
			assign lp_fn[gi] = qual_q[gi] && is_lp(input_function_code[gi]);
			assign lp_man_fn[gi] = lp_fn[gi] && (input_function_code[gi] >= pump_input_pkg::CODE_LP_MAN_NO);

			property p_code_off;
				@(posedge ref_clk) disable iff (rst)
				input_function_code[gi] == pump_input_pkg::CODE_OFF |-> !(aux_fn[gi] | dis_fn[gi] | rst_fn[gi] | lp_fn[gi]);
			endproperty
			a_code_off: assert property (p_code_off) else $error("code zero drives a function");

			sequence s_qual_flip;
				$changed(qual_q[gi]);
			endsequence
			property p_qual_time;
				@(posedge ref_clk) disable iff (rst)
				s_qual_flip |-> $past(cnt_q[gi]) >= $past(need_w[gi]) && $past(raw_w[gi]) == qual_q[gi];
			endproperty
			a_qual_time: assert property (p_qual_time) else $error("input qualified too early");

			property p_timer_restart;
				@(posedge ref_clk) disable iff (rst)
				raw_w[gi] == qual_q[gi] |=> cnt_q[gi] == 18'h00000;
			endproperty
			a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

			property p_aux_target;
				@(posedge ref_clk) disable iff (rst)
				aux_fn == (N_INPUTS'(1) << gi) |=> regulation_setpoint == $past(aux_sp_q[gi]);
			endproperty
			a_aux_target: assert property (p_aux_target) else $error("aux setpoint not applied");

			property p_aux_lowest;
				@(posedge ref_clk) disable iff (rst)
				aux_fn[gi] |=> regulation_setpoint <= $past(aux_sp_q[gi]);
			endproperty
			a_aux_lowest: assert property (p_aux_lowest) else $error("target above an active aux setpoint");
		end
	endgenerate

	// lowest active auxiliary setpoint, else main
	always_comb begin
		logic found;
		found    = 1'b0;
		target_w = main_pressure_setpoint_q;
		for (int i = 0; i < N_INPUTS; i++) begin
			if (aux_fn[i] && (!found || aux_sp_q[i] < target_w)) begin
				target_w = aux_sp_q[i];
				found    = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			regulation_setpoint       <= pump_input_pkg::RST_MAIN_SP;
			aux_setpoint_indicator    <= 1'b0;
			system_disabled_indicator <= 1'b0;
			resettable_block_reset    <= 1'b0;
		end else begin
			regulation_setpoint       <= target_w;
			aux_setpoint_indicator    <= |aux_fn;
			system_disabled_indicator <= |dis_fn;
			resettable_block_reset    <= |rst_fn;
		end
	end

	// low-pressure block with manual-only latch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			man_latch_q <= 1'b0;
			lp_block_q  <= 1'b0;
		end else begin
			if (|lp_man_fn) begin
				man_latch_q <= 1'b1;
			end else if (!(|lp_fn) && (manual_reset_w || (|rst_fn))) begin
				man_latch_q <= 1'b0;
			end
			if (|lp_fn) begin
				lp_block_q <= 1'b1;
			end else if (!man_latch_q || manual_reset_w || (|rst_fn)) begin
				lp_block_q <= 1'b0;
			end
		end
	end
	assign low_pressure_block_indicator = lp_block_q;

	// wishbone slave, one wait state
	assign bus_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_status      = bus_req && !wb_we_i && (wb_adr_i[7:2] == pump_input_pkg::OFF_IRQ_STATUS[7:2]);
	assign manual_reset_w = bus_req && wb_we_i && wb_sel_i[0] && wb_dat_i[0] &&
		(wb_adr_i[7:2] == pump_input_pkg::OFF_COMMAND[7:2]);
	assign wmask          = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			codes_q                      <= pump_input_pkg::RST_CODES;
			main_pressure_setpoint_q     <= pump_input_pkg::RST_MAIN_SP;
			low_pressure_shutoff_delay_q <= pump_input_pkg::RST_SHUTOFF;
			irq_mask_q                   <= pump_input_pkg::RST_IRQ_MASK;
			for (int i = 0; i < N_INPUTS; i++) begin
				aux_sp_q[i] <= pump_input_pkg::RST_AUX_SP;
			end
		end else if (bus_req && wb_we_i) begin
			case (wb_adr_i[7:2])
				pump_input_pkg::OFF_CODES[7:2]: begin
					codes_q <= (codes_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				end
				pump_input_pkg::OFF_MAIN_SP[7:2]: begin
					main_pressure_setpoint_q <= (main_pressure_setpoint_q & ~wmask[SP_W-1:0]) |
						(wb_dat_i[SP_W-1:0] & wmask[SP_W-1:0]);
				end
				pump_input_pkg::OFF_SHUTOFF[7:2]: begin
					if (wb_sel_i[0]) begin
						low_pressure_shutoff_delay_q <= wb_dat_i[7:0];
					end
				end
				pump_input_pkg::OFF_IRQ_MASK[7:2]: begin
					if (wb_sel_i[0]) begin
						irq_mask_q <= wb_dat_i[3:0];
					end
				end
				default: begin
					for (int i = 0; i < N_INPUTS; i++) begin
						if (wb_adr_i[7:2] == 6'(pump_input_pkg::OFF_AUX_SP0[7:2] + 6'(i))) begin
							aux_sp_q[i] <= (aux_sp_q[i] & ~wmask[SP_W-1:0]) | (wb_dat_i[SP_W-1:0] & wmask[SP_W-1:0]);
						end
					end
				end
			endcase
		end
	end

	// events: aux, disable, low pressure, block reset rising
	assign events_w = {(|rst_fn) & !resettable_block_reset, (|lp_fn) & !lp_block_q,
		(|dis_fn) & !system_disabled_indicator, (|aux_fn) & !aux_setpoint_indicator};

	// mask as it stands after this edge, so irq never lags a mask write
	assign irq_mask_d = (bus_req && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i[7:2] == pump_input_pkg::OFF_IRQ_MASK[7:2])) ? wb_dat_i[3:0] : irq_mask_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status_q <= 4'h0;
			irq          <= 1'b0;
		end else begin
			irq_status_q <= (rd_status ? 4'h0 : irq_status_q) | events_w;
			irq          <= |(((rd_status ? 4'h0 : irq_status_q) | events_w) & irq_mask_d);
		end
	end

	always_comb begin
		rdata_w = 32'h00000000;
		case (wb_adr_i[7:2])
			pump_input_pkg::OFF_CODES[7:2]:      rdata_w[15:0] = codes_q;
			pump_input_pkg::OFF_MAIN_SP[7:2]:    rdata_w[SP_W-1:0] = main_pressure_setpoint_q;
			pump_input_pkg::OFF_AUX_SP0[7:2]:    rdata_w[SP_W-1:0] = aux_sp_q[0];
			pump_input_pkg::OFF_AUX_SP1[7:2]:    rdata_w[SP_W-1:0] = aux_sp_q[1];
			pump_input_pkg::OFF_AUX_SP2[7:2]:    rdata_w[SP_W-1:0] = aux_sp_q[2];
			pump_input_pkg::OFF_AUX_SP3[7:2]:    rdata_w[SP_W-1:0] = aux_sp_q[3];
			pump_input_pkg::OFF_SHUTOFF[7:2]:    rdata_w[7:0] = low_pressure_shutoff_delay_q;
			pump_input_pkg::OFF_STATE[7:2]:      rdata_w[15:0] = {4'(lvl_q), 4'(qual_q), man_latch_q,
				resettable_block_reset, lp_block_q, system_disabled_indicator, 3'h0, aux_setpoint_indicator};
			pump_input_pkg::OFF_IRQ_STATUS[7:2]: rdata_w[3:0] = irq_status_q;
			pump_input_pkg::OFF_IRQ_MASK[7:2]:   rdata_w[3:0] = irq_mask_q;
			pump_input_pkg::OFF_TARGET[7:2]:     rdata_w[SP_W-1:0] = regulation_setpoint;
			default:                             rdata_w = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req && !wb_we_i ? rdata_w : 32'h00000000;
		end
	end

	property p_aux_ind;
		@(posedge ref_clk) disable iff (rst)
		|aux_fn |=> aux_setpoint_indicator;
	endproperty
	a_aux_ind: assert property (p_aux_ind) else $error("aux indication missing");

	property p_aux_ind_clear;
		@(posedge ref_clk) disable iff (rst)
		aux_fn == '0 |=> !aux_setpoint_indicator && regulation_setpoint == $past(main_pressure_setpoint_q);
	endproperty
	a_aux_ind_clear: assert property (p_aux_ind_clear) else $error("main setpoint not restored");

	property p_dis_ind;
		@(posedge ref_clk) disable iff (rst)
		##1 system_disabled_indicator == $past(|dis_fn);
	endproperty
	a_dis_ind: assert property (p_dis_ind) else $error("disable indication wrong");

	property p_reset_only;
		@(posedge ref_clk) disable iff (rst)
		rst_fn == '0 |=> !resettable_block_reset;
	endproperty
	a_reset_only: assert property (p_reset_only) else $error("block reset without function");

	sequence s_lp_seen;
		|lp_fn;
	endsequence
	property p_lp_block;
		@(posedge ref_clk) disable iff (rst)
		s_lp_seen ##1 s_lp_seen |-> lp_block_q [*2];
	endproperty
	a_lp_block: assert property (p_lp_block) else $error("low pressure block not held");

	property p_lp_manual;
		@(posedge ref_clk) disable iff (rst)
		man_latch_q && !manual_reset_w && rst_fn == '0 && lp_block_q |=> lp_block_q;
	endproperty
	a_lp_manual: assert property (p_lp_manual) else $error("manual-only block released");

	property p_blk_rst;
		@(posedge ref_clk) disable iff (rst)
		|rst_fn |=> resettable_block_reset;
	endproperty
	a_blk_rst: assert property (p_blk_rst) else $error("block reset missing");

	property p_irq_level;
		@(posedge ref_clk) disable iff (rst)
		irq == |(irq_status_q & irq_mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq does not follow unmasked status");

	property p_ack_pulse;
		@(posedge ref_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

endmodule

// file: pump_input_function_logic_tb.sv
// self-checking bench for the auxiliary input function block
// assumes the design package, the design and the contact_bank model are compiled first
module pump_input_function_logic_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 2;
	localparam int Q  = int'(pump_input_pkg::QUAL_TICKS) * TK;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] dat     = 32'h0;
	logic [3:0]  level   = 4'h0;
	logic [3:0]  chatter = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [3:0]  pins;
	logic [15:0] setpoint;
	logic        aux_ind, dis_ind, blk_rst, lp_ind, irq;
	int          err_count = 0;
	int          compares  = 0;

	always #5 ref_clk = ~ref_clk;

	contact_bank far (.ref_clk(ref_clk), .level(level), .chatter(chatter), .contact_out(pins));

	pump_input_function_logic #(.TICK_CYCLES(TK)) dut (
		.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.auxiliary_digital_input(pins), .regulation_setpoint(setpoint),
		.aux_setpoint_indicator(aux_ind), .system_disabled_indicator(dis_ind),
		.resettable_block_reset(blk_rst), .low_pressure_block_indicator(lp_ind), .irq(irq)
	);

	task automatic summarize();
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cw(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		do begin
			@(posedge ref_clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		if (w) begin
			chk("wb_dat_o", 32'h0, wb_dat_o);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(name, exp, q);
	endtask

	// f holds {low pressure, block reset, disabled, aux}
	task automatic outs(input logic [15:0] sp, input logic [3:0] f);
		chk("regulation_setpoint", {16'h0, sp}, {16'h0, setpoint});
		chk("indicators", {28'h0, f}, {28'h0, lp_ind, blk_rst, dis_ind, aux_ind});
	endtask

	task automatic t_reset();
		rd_chk("codes", pump_input_pkg::OFF_CODES, {16'h0, pump_input_pkg::RST_CODES});
		rd_chk("shutoff", pump_input_pkg::OFF_SHUTOFF, {24'h0, pump_input_pkg::RST_SHUTOFF});
		rd_chk("main_sp", pump_input_pkg::OFF_MAIN_SP, {16'h0, pump_input_pkg::RST_MAIN_SP});
		rd_chk("irq_mask", pump_input_pkg::OFF_IRQ_MASK, {28'h0, pump_input_pkg::RST_IRQ_MASK});
		rd_chk("unmapped", 8'h30, 32'h0);
		outs(16'h0000, 4'h0);
	endtask

	task automatic t_code_zero();
		wr(pump_input_pkg::OFF_CODES, 32'h0);
		wr(pump_input_pkg::OFF_MAIN_SP, 32'h0100);
		level <= 4'hF;
		cw(Q + 20);
		outs(16'h0100, 4'h0);
		level <= 4'h0;
		cw(Q + 20);
	endtask

	task automatic t_aux();
		wr(pump_input_pkg::OFF_AUX_SP0, 32'h0080);
		wr(pump_input_pkg::OFF_AUX_SP1, 32'h0060);
		wr(pump_input_pkg::OFF_AUX_SP3, 32'h0040);
		wr(pump_input_pkg::OFF_CODES, 32'h3531);
		level[1] <= 1'b1;
		chatter  <= 4'h2;
		cw(20);
		chatter  <= 4'h0;
		cw(1000);
		level[1] <= 1'b0;
		cw(10);
		level[1] <= 1'b1;
		cw(Q - 20);
		outs(16'h0100, 4'h0);
		cw(40);
		outs(16'h0060, 4'h1);
		level[3] <= 1'b1;
		cw(Q + 20);
		outs(16'h0040, 4'h1);
		level[3] <= 1'b0;
		cw(Q + 20);
		outs(16'h0060, 4'h1);
		level[1] <= 1'b0;
		cw(Q - 20);
		outs(16'h0060, 4'h1);
		cw(40);
		outs(16'h0100, 4'h0);
		wr(pump_input_pkg::OFF_CODES, 32'h3534);
		cw(Q + 20);
		outs(16'h0080, 4'h1);
		level[0] <= 1'b1;
		cw(Q + 20);
		outs(16'h0100, 4'h0);
	endtask

	task automatic t_disable();
		logic [31:0] q;
		logic        ina;
		logic [3:0]  f;
		wr(pump_input_pkg::OFF_IRQ_MASK, 32'h2);
		wb(1'b0, pump_input_pkg::OFF_IRQ_STATUS, 32'h0, q);
		for (int c = 5; c <= 9; c++) begin
			ina = (c == 6 || c == 8);
			f   = {1'b0, c >= 7, c <= 8, 1'b0};
			level <= {1'b0, ina, 2'b00};
			wr(pump_input_pkg::OFF_CODES, {20'h0, 4'(c), 8'h00});
			cw(Q + 20);
			outs(16'h0100, 4'h0);
			level[2] <= ~ina;
			cw(Q - 20);
			outs(16'h0100, 4'h0);
			cw(40);
			outs(16'h0100, f);
			if (c == 5) begin
				chk("irq", 32'h1, {31'h0, irq});
				rd_chk("irq_status", pump_input_pkg::OFF_IRQ_STATUS, 32'h2);
				cw(2);
				chk("irq", 32'h0, {31'h0, irq});
			end
			level[2] <= ina;
			cw(Q - 20);
			outs(16'h0100, f);
			cw(40);
			outs(16'h0100, 4'h0);
		end
	endtask

	task automatic t_lowp();
		rd_chk("target", pump_input_pkg::OFF_TARGET, 32'h0100);
		wr(pump_input_pkg::OFF_SHUTOFF, 32'h1);
		wr(pump_input_pkg::OFF_CODES, 32'h000A);
		level[0] <= 1'b1;
		cw(Q - 20);
		outs(16'h0100, 4'h0);
		cw(40);
		outs(16'h0100, 4'h8);
		level[0] <= 1'b0;
		cw(2 * Q - 20);
		outs(16'h0100, 4'h8);
		cw(40);
		outs(16'h0100, 4'h0);
		wr(pump_input_pkg::OFF_CODES, 32'h000C);
		level[0] <= 1'b1;
		cw(Q + 20);
		outs(16'h0100, 4'h8);
		level[0] <= 1'b0;
		cw(2 * Q + 20);
		outs(16'h0100, 4'h8);
		wr(pump_input_pkg::OFF_COMMAND, 32'h1);
		cw(3);
		outs(16'h0100, 4'h0);
		level[0] <= 1'b1;
		wr(pump_input_pkg::OFF_CODES, 32'h000B);
		wr(pump_input_pkg::OFF_SHUTOFF, 32'h0);
		cw(20);
		outs(16'h0100, 4'h0);
		level[0] <= 1'b0;
		cw(20);
		outs(16'h0100, 4'h8);
		level[0] <= 1'b1;
		cw(2 * Q + 20);
		outs(16'h0100, 4'h0);
		wr(pump_input_pkg::OFF_CODES, 32'h000D);
		level[0] <= 1'b0;
		cw(20);
		outs(16'h0100, 4'h8);
		rd_chk("state", pump_input_pkg::OFF_STATE, 32'h01A0);
	endtask

	initial begin
		cw(12);
		rst <= 1'b0;
		t_reset();
		t_code_zero();
		t_aux();
		t_disable();
		t_lowp();
		summarize();
	end

	initial begin
		#1000000;
		err_count++;
		summarize();
	end
endmodule

// file: pump_input_pkg.sv
// constants for the auxiliary input function block
// assumes a 100 MHz system clock and a classic wishbone register bus
package pump_input_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CODES      = 8'h00;
	localparam logic [7:0] OFF_MAIN_SP    = 8'h04;
	localparam logic [7:0] OFF_AUX_SP0    = 8'h08;
	localparam logic [7:0] OFF_AUX_SP1    = 8'h0C;
	localparam logic [7:0] OFF_AUX_SP2    = 8'h10;
	localparam logic [7:0] OFF_AUX_SP3    = 8'h14;
	localparam logic [7:0] OFF_SHUTOFF    = 8'h18;
	localparam logic [7:0] OFF_COMMAND    = 8'h1C;
	localparam logic [7:0] OFF_STATE      = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h28;
	localparam logic [7:0] OFF_TARGET     = 8'h2C;

	// reset values
	localparam logic [15:0] RST_CODES    = 16'h0531;
	localparam logic [15:0] RST_MAIN_SP  = 16'h0000;
	localparam logic [15:0] RST_AUX_SP   = 16'h0000;
	localparam logic [7:0]  RST_SHUTOFF  = 8'h0A;
	localparam logic [3:0]  RST_IRQ_MASK = 4'h0;

	// input function codes
	localparam logic [3:0] CODE_OFF        = 4'h0;
	localparam logic [3:0] CODE_AUX_NO     = 4'h3;
	localparam logic [3:0] CODE_AUX_NC     = 4'h4;
	localparam logic [3:0] CODE_DIS_NO     = 4'h5;
	localparam logic [3:0] CODE_DIS_NC     = 4'h6;
	localparam logic [3:0] CODE_DIS_RST_NO = 4'h7;
	localparam logic [3:0] CODE_DIS_RST_NC = 4'h8;
	localparam logic [3:0] CODE_RST_NO     = 4'h9;
	localparam logic [3:0] CODE_LP_AUTO_NO = 4'hA;
	localparam logic [3:0] CODE_LP_AUTO_NC = 4'hB;
	localparam logic [3:0] CODE_LP_MAN_NO  = 4'hC;
	localparam logic [3:0] CODE_LP_MAN_NC  = 4'hD;

	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TICK_PERIOD_NS  = 1000000;
	localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int QUAL_TIME_MS    = 1000;
	localparam int UNBLOCK_TIME_MS = 2000;
	localparam int MS_PER_S        = 1000;
	localparam logic [17:0] QUAL_TICKS    = 18'(QUAL_TIME_MS * 1000000 / TICK_PERIOD_NS);
	localparam logic [17:0] UNBLOCK_TICKS = 18'(UNBLOCK_TIME_MS * 1000000 / TICK_PERIOD_NS);
	localparam logic [17:0] TICKS_PER_S   = 18'(MS_PER_S * 1000000 / TICK_PERIOD_NS);

endpackage
